/* shared/gpio_port_pkg.sv */
// Behaviour
// - Receiver enabled puts both port pins in high impedance, overriding direction and data.
// - Normal data, pull-up and direction control apply only while the receiver is disabled.
// - Data register reads return the pin level for bits configured as inputs.
// - Data register reads return the last written value for bits configured as outputs.
// - Every data register write is stored in all implemented bits, whatever direction.
// - Bits configured as outputs drive the stored data level onto their pin.
// - Reset clears data to zero without driving it; pins become inputs, pull-ups off.
// - Pull-up enable bit 0 turns the pin pull-up off, 1 turns it on.
// - Pins configured as outputs keep the pull-up off whatever the enable bit says.
// - Direction bit 0 makes an input with driver off; 1 enables the driver.
// - Direction register reads return the stored direction bits.
package gpio_port_pkg;

    // ------------------------------------------------------------------
    // Widths
    // ------------------------------------------------------------------

    // Implemented pins of the port and width of each register.
    localparam int PORT_WIDTH = 2;
    localparam int REG_WIDTH = 8;
    localparam int ADDR_WIDTH = 8;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------

    // Offsets are byte addresses on the register port.
    localparam logic [ADDR_WIDTH-1:0] OFF_PORT_DATA = 8'h04;
    localparam logic [ADDR_WIDTH-1:0] OFF_PORT_PULLUP_ENABLE = 8'h05;
    localparam logic [ADDR_WIDTH-1:0] OFF_PORT_DIRECTION = 8'h07;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------

    // All registers and pin controls clear on reset.
    localparam logic [PORT_WIDTH-1:0] RST_PORT_DATA = 2'h0;
    localparam logic [PORT_WIDTH-1:0] RST_PORT_PULLUP_ENABLE = 2'h0;
    localparam logic [PORT_WIDTH-1:0] RST_PORT_DIRECTION = 2'h0;
    localparam logic [PORT_WIDTH-1:0] RST_PIN_CTRL = 2'h0;
    localparam logic [REG_WIDTH-1:0] RST_READ_DATA = 8'h00;

    // Value returned for unmapped addresses and unimplemented bits.
    localparam logic [REG_WIDTH-1:0] UNMAPPED_READ = 8'h00;
    localparam logic [REG_WIDTH-PORT_WIDTH-1:0] UPPER_ZERO = 6'h00;

endpackage

/* rtl/two_bit_gpio_port.sv */
`timescale 1ns/1ps
module two_bit_gpio_port
    import gpio_port_pkg::*;
(
    // Clock and reset.
    input wire logic core_clk,
    input wire logic reset_n,
    // Register port.
    input wire logic [ADDR_WIDTH-1:0] reg_addr,
    input wire logic [REG_WIDTH-1:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [REG_WIDTH-1:0] reg_rdata,
    // Receiver sharing the pins.
    input wire logic low_frequency_receiver_enable,
    // Port pins.
    input wire logic [PORT_WIDTH-1:0] port_pins_in,
    output logic [PORT_WIDTH-1:0] port_pins_out,
    output logic [PORT_WIDTH-1:0] port_pins_oe,
    output logic [PORT_WIDTH-1:0] pin_pullup_on
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Keeps only the implemented bits of a bus word.
    function automatic logic [PORT_WIDTH-1:0] low_bits(input logic [REG_WIDTH-1:0] word);
        low_bits = word[PORT_WIDTH-1:0];
    endfunction

    // Widens a port value to a bus word with the upper bits zero.
    function automatic logic [REG_WIDTH-1:0] to_word(input logic [PORT_WIDTH-1:0] bits);
        to_word = {UPPER_ZERO, bits};
    endfunction

    // ------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------

    logic [PORT_WIDTH-1:0] port_data_bits_q;
    logic [PORT_WIDTH-1:0] port_data_bits_d;
    logic [PORT_WIDTH-1:0] pin_pullup_enable_bits_q;
    logic [PORT_WIDTH-1:0] pin_pullup_enable_bits_d;
    logic [PORT_WIDTH-1:0] pin_direction_bits_q;
    logic [PORT_WIDTH-1:0] pin_direction_bits_d;
    logic [REG_WIDTH-1:0] rdata_d;
    logic [PORT_WIDTH-1:0] data_view;
    logic write_data;
    logic write_pullup;
    logic write_direction;

    // Address decode of the write strobe.
    assign write_data = reg_write && (reg_addr == OFF_PORT_DATA);
    assign write_pullup = reg_write && (reg_addr == OFF_PORT_PULLUP_ENABLE);
    assign write_direction = reg_write && (reg_addr == OFF_PORT_DIRECTION);

    // Next register values; upper bits of the write data are dropped.
    always_comb begin
        port_data_bits_d = port_data_bits_q;
        pin_pullup_enable_bits_d = pin_pullup_enable_bits_q;
        pin_direction_bits_d = pin_direction_bits_q;
        if (write_data) begin
            port_data_bits_d = low_bits(reg_wdata);
        end
        if (write_pullup) begin
            pin_pullup_enable_bits_d = low_bits(reg_wdata);
        end
        if (write_direction) begin
            pin_direction_bits_d = low_bits(reg_wdata);
        end
    end

    // Data register, stored regardless of direction.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_data_bits_q <= RST_PORT_DATA;
        end else begin
            port_data_bits_q <= port_data_bits_d;
        end
    end

    // Pull-up enable register.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_pullup_enable_bits_q <= RST_PORT_PULLUP_ENABLE;
        end else begin
            pin_pullup_enable_bits_q <= pin_pullup_enable_bits_d;
        end
    end

    // Direction register.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_direction_bits_q <= RST_PORT_DIRECTION;
        end else begin
            pin_direction_bits_q <= pin_direction_bits_d;
        end
    end

    // ------------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------------

    // Input bits show the pin, output bits show the stored value.
    assign data_view = (port_pins_in & ~pin_direction_bits_q)
                     | (port_data_bits_q & pin_direction_bits_q);

    // Read multiplexer; unmapped addresses answer zero.
    always_comb begin
        rdata_d = reg_rdata;
        if (reg_read) begin
            unique case (reg_addr)
                OFF_PORT_DATA: rdata_d = to_word(data_view);
                OFF_PORT_PULLUP_ENABLE: rdata_d = to_word(pin_pullup_enable_bits_q);
                OFF_PORT_DIRECTION: rdata_d = to_word(pin_direction_bits_q);
                default: rdata_d = UNMAPPED_READ;
            endcase
        end
    end

    // Read data stands in the cycle after the strobe and holds until the next read.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reg_rdata <= RST_READ_DATA;
        end else begin
            reg_rdata <= rdata_d;
        end
    end

    // ------------------------------------------------------------------
    // Pin control
    // ------------------------------------------------------------------

    // Drive level always follows the stored data; the enable decides if it reaches the pin.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_pins_out <= RST_PIN_CTRL;
        end else begin
            port_pins_out <= port_data_bits_d;
        end
    end

    // Output drivers are on only for output bits while the receiver is off.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            port_pins_oe <= RST_PIN_CTRL;
        end else if (low_frequency_receiver_enable) begin
            port_pins_oe <= RST_PIN_CTRL;
        end else begin
            port_pins_oe <= pin_direction_bits_d;
        end
    end

    // Pull-ups are on only for enabled input bits while the receiver is off.
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            pin_pullup_on <= RST_PIN_CTRL;
        end else if (low_frequency_receiver_enable) begin
            pin_pullup_on <= RST_PIN_CTRL;
        end else begin
            pin_pullup_on <= pin_pullup_enable_bits_d & ~pin_direction_bits_d;
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (!reset_n);

    // A read strobe to the data register.
    sequence data_read_s;
        reg_read && (reg_addr == OFF_PORT_DATA);
    endsequence

    // A read strobe to the direction register.
    sequence dir_read_s;
        reg_read && (reg_addr == OFF_PORT_DIRECTION);
    endsequence

    // The receiver being on removes all drive and pull-up in the next cycle.
    a_receiver_pins_hiz: assert property (
        low_frequency_receiver_enable |=> (port_pins_oe == RST_PIN_CTRL)
            && (pin_pullup_on == RST_PIN_CTRL))
        else $error("pins not released while receiver enabled");

    // Driver enables follow the direction bits when the receiver was off.
    a_normal_drive_enable: assert property (
        !$past(low_frequency_receiver_enable) |-> (port_pins_oe == pin_direction_bits_q))
        else $error("driver enable does not follow direction");

    // Input bits of a data read return the pins seen at the strobe.
    a_read_input_pins: assert property (
        data_read_s |=> ((reg_rdata[PORT_WIDTH-1:0] ^ $past(port_pins_in))
            & ~$past(pin_direction_bits_q)) == RST_PIN_CTRL)
        else $error("input bit read does not show pin level");

    // Output bits of a data read return the stored value.
    a_read_output_data: assert property (
        data_read_s |=> ((reg_rdata[PORT_WIDTH-1:0] ^ $past(port_data_bits_q))
            & $past(pin_direction_bits_q)) == RST_PIN_CTRL)
        else $error("output bit read does not show stored data");

    // A data write lands in all implemented bits.
    a_data_write_store: assert property (
        write_data |=> port_data_bits_q == $past(reg_wdata[PORT_WIDTH-1:0]))
        else $error("data write not stored");

    // A driven pin carries the stored data level.
    a_output_level: assert property (
        (port_pins_out & port_pins_oe) == (port_data_bits_q & port_pins_oe))
        else $error("driven pin does not carry stored data");

    // During reset nothing is driven, pulled or stored.
    a_reset_quiet: assert property (
        disable iff (1'b0) !reset_n |-> (port_data_bits_q == RST_PORT_DATA)
            && (port_pins_oe == RST_PIN_CTRL) && (pin_pullup_on == RST_PIN_CTRL))
        else $error("pins or data not cleared in reset");

    // Pull-up follows its enable on input bits with the receiver off.
    a_pullup_select: assert property (
        pin_pullup_on == ($past(low_frequency_receiver_enable) ? RST_PIN_CTRL
            : (pin_pullup_enable_bits_q & ~pin_direction_bits_q)))
        else $error("pull-up does not follow its enable");

    // A pin is never driven and pulled up at once.
    a_no_pullup_output: assert property (
        (pin_pullup_on & port_pins_oe) == RST_PIN_CTRL)
        else $error("pull-up active on an output pin");

    // A direction write reaches the driver enable one cycle later.
    a_dir_to_driver: assert property (
        write_direction && !low_frequency_receiver_enable
            |=> port_pins_oe == $past(reg_wdata[PORT_WIDTH-1:0]))
        else $error("direction write did not reach driver");

    // Direction reads return the stored bits.
    a_dir_readback: assert property (
        dir_read_s |=> reg_rdata == to_word($past(pin_direction_bits_q)))
        else $error("direction read mismatch");

    // Upper bits of every read are zero.
    a_upper_bits_zero: assert property (
        reg_read |=> reg_rdata[REG_WIDTH-1:PORT_WIDTH] == UPPER_ZERO)
        else $error("unimplemented bits read nonzero");

    // ------------------------------------------------------------------
    // Assertion helpers
    // ------------------------------------------------------------------

    // High when the bus address names one of the three port registers.
    logic addr_mapped;
    assign addr_mapped = (reg_addr == OFF_PORT_DATA)
                       || (reg_addr == OFF_PORT_PULLUP_ENABLE)
                       || (reg_addr == OFF_PORT_DIRECTION);

    // A read strobe to the pull-up enable register.
    sequence pullup_read_s;
        reg_read && (reg_addr == OFF_PORT_PULLUP_ENABLE);
    endsequence

    // The receiver switching off after at least one cycle on.
    sequence receiver_release_s;
        low_frequency_receiver_enable ##1 !low_frequency_receiver_enable;
    endsequence

    // The receiver staying on for two cycles in a row.
    sequence receiver_held_s;
        low_frequency_receiver_enable ##1 low_frequency_receiver_enable;
    endsequence

    // A pull-up write while the receiver leaves the pins to the port.
    sequence pullup_write_s;
        write_pullup && !low_frequency_receiver_enable;
    endsequence

    // ------------------------------------------------------------------
    // Register and release checks
    // ------------------------------------------------------------------

    // Pull-up enable reads return the stored bits.
    a_pullup_readback: assert property (
        pullup_read_s |=> reg_rdata == to_word($past(pin_pullup_enable_bits_q)))
        else $error("pull-up enable read mismatch");

    // A pull-up write lands in the implemented bits.
    a_pullup_write_store: assert property (
        write_pullup |=> pin_pullup_enable_bits_q == $past(reg_wdata[PORT_WIDTH-1:0]))
        else $error("pull-up enable write not stored");

    // A direction write lands in the implemented bits.
    a_dir_write_store: assert property (
        write_direction |=> pin_direction_bits_q == $past(reg_wdata[PORT_WIDTH-1:0]))
        else $error("direction write not stored");

    // The data register changes only on a data write.
    a_data_hold_idle: assert property (
        !write_data |=> $stable(port_data_bits_q))
        else $error("data register changed without a write");

    // The configuration registers change only on their own writes.
    a_config_hold_idle: assert property (
        !write_pullup && !write_direction
            |=> $stable(pin_pullup_enable_bits_q) && $stable(pin_direction_bits_q))
        else $error("configuration changed without a write");

    // Writes to unmapped addresses leave every register alone.
    a_unmapped_write_quiet: assert property (
        reg_write && !addr_mapped |=> $stable(port_data_bits_q)
            && $stable(pin_pullup_enable_bits_q) && $stable(pin_direction_bits_q))
        else $error("unmapped write changed a register");

    // Reads of unmapped addresses answer zero.
    a_unmapped_read_zero: assert property (
        reg_read && !addr_mapped |=> reg_rdata == UNMAPPED_READ)
        else $error("unmapped read returned nonzero");

    // Read data hold between read strobes.
    a_rdata_hold_idle: assert property (
        !reg_read |=> $stable(reg_rdata))
        else $error("read data changed without a read");

    // A receiver that stays on keeps every driver and pull-up off.
    a_receiver_held_off: assert property (
        receiver_held_s |-> (port_pins_oe == RST_PIN_CTRL)
            && (pin_pullup_on == RST_PIN_CTRL))
        else $error("pins active while receiver stays enabled");

    // After the receiver lets go, drivers and pull-ups follow the registers again.
    a_receiver_release: assert property (
        receiver_release_s |=> (port_pins_oe == pin_direction_bits_q)
            && (pin_pullup_on == (pin_pullup_enable_bits_q & ~pin_direction_bits_q)))
        else $error("pins not returned to port after receiver release");

    // A pull-up write reaches the pin control one cycle later on input bits.
    a_pullup_to_pin: assert property (
        pullup_write_s |=> pin_pullup_on
            == ($past(reg_wdata[PORT_WIDTH-1:0]) & ~pin_direction_bits_q))
        else $error("pull-up write did not reach pin control");

    // The drive level always equals the stored data.
    a_out_tracks_data: assert property (
        port_pins_out == port_data_bits_q)
        else $error("drive level differs from stored data");

    // Right after reset release nothing is driven, pulled or stored.
    a_release_quiet: assert property (
        $rose(reset_n) |-> (port_pins_oe == RST_PIN_CTRL)
            && (pin_pullup_on == RST_PIN_CTRL) && (port_data_bits_q == RST_PORT_DATA))
        else $error("pins active right after reset release");

endmodule

/* verification/pin_far_side.sv */
`timescale 1ns/1ps
module pin_far_side
    import gpio_port_pkg::*;
(
    // Clock.
    input wire logic core_clk,
    // Pin controls from the port.
    input wire logic [PORT_WIDTH-1:0] port_pins_out,
    input wire logic [PORT_WIDTH-1:0] port_pins_oe,
    input wire logic [PORT_WIDTH-1:0] pin_pullup_on,
    // External source on the board.
    input wire logic [PORT_WIDTH-1:0] ext_level,
    input wire logic ext_drive,
    // Resolved pin level.
    output logic [PORT_WIDTH-1:0] port_pins_in
);
    logic [PORT_WIDTH-1:0] float_q = 2'h1;

    // A floating pin wanders every cycle, so a stale level never passes for a real one.
    always @(posedge core_clk) begin
        float_q <= ~float_q;
    end

    // Own driver wins, then the external source, then the pull-up, else the pin floats.
    always_comb begin
        for (int i = 0; i < PORT_WIDTH; i++) begin
            if (port_pins_oe[i]) begin
                port_pins_in[i] = port_pins_out[i];
            end else if (ext_drive) begin
                port_pins_in[i] = ext_level[i];
            end else if (pin_pullup_on[i]) begin
                port_pins_in[i] = 1'b1;
            end else begin
                port_pins_in[i] = float_q[i];
            end
        end
    end
endmodule

/* verification/two_bit_gpio_port_test.sv */
`timescale 1ns/1ps
module two_bit_gpio_port_test;
    import gpio_port_pkg::*;
    logic core_clk = 1'b0;
    logic reset_n;
    logic [ADDR_WIDTH-1:0] reg_addr = 8'h00;
    logic [REG_WIDTH-1:0] reg_wdata = 8'h00;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic [REG_WIDTH-1:0] reg_rdata;
    logic low_frequency_receiver_enable = 1'b0;
    logic [PORT_WIDTH-1:0] port_pins_in, port_pins_out, port_pins_oe, pin_pullup_on;
    logic [PORT_WIDTH-1:0] ext_level = 2'h0;
    logic ext_drive = 1'b1;
    logic rd_seen = 1'b0;
    logic [REG_WIDTH-1:0] exp_q[$];
    logic [15:0] lfsr = 16'd6506;
    logic [7:0] d, p, v, e;
    int n_errors = 0;
    int n_checks = 0;

    // ------------------------------------------------------------------
    // Clock, design and far side
    // ------------------------------------------------------------------

    // The clock toggles every half period of 12.5 ns.
    always #12.5 core_clk = ~core_clk;

    two_bit_gpio_port DUT (.core_clk(core_clk), .reset_n(reset_n), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read),
        .reg_rdata(reg_rdata), .low_frequency_receiver_enable(low_frequency_receiver_enable),
        .port_pins_in(port_pins_in), .port_pins_out(port_pins_out),
        .port_pins_oe(port_pins_oe), .pin_pullup_on(pin_pullup_on));

    pin_far_side pins (.core_clk(core_clk), .port_pins_out(port_pins_out),
        .port_pins_oe(port_pins_oe), .pin_pullup_on(pin_pullup_on),
        .ext_level(ext_level), .ext_drive(ext_drive), .port_pins_in(port_pins_in));

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Steps the shift register eight times and returns a fresh byte.
    function automatic logic [7:0] rnd();
        for (int i = 0; i < 8; i++) begin
            lfsr = {lfsr[14:0], lfsr[15] ^ lfsr[13] ^ lfsr[12] ^ lfsr[10]};
        end
        return lfsr[7:0];
    endfunction

    // Prints the counts and the verdict, then stops.
    task automatic end_sim();
        $display("Checks %0d, errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    // Compares one byte and reports a difference.
    task automatic check8(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // Compares the pin controls once they have settled.
    task automatic check_pins(input logic [1:0] oe, input logic [1:0] out, input logic [1:0] pu);
        @(negedge core_clk);
        check8({2'h0, port_pins_oe, port_pins_out, pin_pullup_on}, {2'h0, oe, out, pu});
    endtask

    // One-cycle write strobe.
    task automatic write_reg(input logic [7:0] a, input logic [7:0] w);
        @(posedge core_clk);
        reg_addr <= a;
        reg_wdata <= w;
        reg_write <= 1'b1;
        @(posedge core_clk);
        reg_write <= 1'b0;
    endtask

    // One-cycle read strobe; the expected byte is queued for the monitor.
    task automatic read_reg(input logic [7:0] a, input logic [7:0] x);
        @(posedge core_clk);
        reg_addr <= a;
        reg_read <= 1'b1;
        exp_q.push_back(x);
        @(posedge core_clk);
        reg_read <= 1'b0;
    endtask

    // ------------------------------------------------------------------
    // Read monitor and watchdog
    // ------------------------------------------------------------------

    // Read data is compared in the cycle after the strobe.
    always @(posedge core_clk) begin
        rd_seen <= reg_read;
    end
    always @(negedge core_clk) begin
        if (rd_seen) begin
            check8(reg_rdata, exp_q.pop_front());
        end
    end

    // Cuts a hung run short and counts it as a mismatch.
    initial begin
        repeat (20000) @(posedge core_clk);
        n_errors++;
        $display("Watchdog expired at %0t", $time);
        end_sim();
    end

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------

    // Reset, pull-up check, random sweep, then a second reset.
    initial begin
        reset_n <= 1'b0;
        repeat (10) @(posedge core_clk);
        reset_n <= 1'b1;
        check_pins(2'h0, 2'h0, 2'h0);
        read_reg(OFF_PORT_DATA, 8'h00);
        read_reg(OFF_PORT_PULLUP_ENABLE, 8'h00);
        read_reg(OFF_PORT_DIRECTION, 8'h00);
        ext_drive <= 1'b0;
        write_reg(OFF_PORT_PULLUP_ENABLE, 8'hff);
        check_pins(2'h0, 2'h0, 2'h3);
        read_reg(OFF_PORT_DATA, 8'h03);
        ext_drive <= 1'b1;
        for (int i = 0; i < 16; i++) begin
            d = rnd();
            p = rnd();
            v = rnd();
            e = rnd();
            low_frequency_receiver_enable <= e[7];
            ext_level <= e[1:0];
            write_reg(OFF_PORT_DATA, v);
            write_reg(OFF_PORT_PULLUP_ENABLE, p);
            write_reg(OFF_PORT_DIRECTION, d);
            write_reg(8'h06, rnd());
            check_pins(e[7] ? 2'h0 : d[1:0], v[1:0],
                p[1:0] & ~d[1:0] & {2{~e[7]}});
            read_reg(OFF_PORT_DATA,
                {6'h00, (d[1:0] & v[1:0]) | (~d[1:0] & e[1:0])});
            read_reg(OFF_PORT_PULLUP_ENABLE, {6'h00, p[1:0]});
            read_reg(OFF_PORT_DIRECTION, {6'h00, d[1:0]});
            read_reg(8'h06, 8'h00);
        end
        reset_n <= 1'b0;
        @(posedge core_clk);
        reset_n <= 1'b1;
        check_pins(2'h0, 2'h0, 2'h0);
        read_reg(OFF_PORT_DIRECTION, 8'h00);
        repeat (2) @(posedge core_clk);
        end_sim();
    end
endmodule
